/* design/doc_cal_top.sv */
`timescale 1ns/10ps
`default_nettype none
// dark-offset calibration command handling
module doc_cal_top #(
  parameter int NUM_COLS = doc_pkg::NUM_COLS,
  parameter int NUM_ROWS = doc_pkg::NUM_ROWS,
  parameter int LED_HALF_CYC = doc_pkg::LED_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // configuration
  input wire logic coef_set_sel,
  input wire logic [3:0] exp_mode,
  input wire logic [15:0] user_gain,
  // whole-sensor command
  input wire logic cal_start,
  // single-pixel command
  input wire logic pix_wr,
  input wire logic [15:0] pix_col,
  input wire logic [15:0] pix_row,
  input wire logic [15:0] pix_val,
  // dark pixel stream during calibration
  input wire logic dark_valid,
  input wire logic [9:0] dark_data,
  // coefficient store write port
  output logic coef_wr_en_r,
  output logic [10:0] coef_col_r,
  output logic [10:0] coef_row_r,
  output logic [7:0] coef_dat_r,
  // non-volatile save request
  output logic nvm_save_r,
  // gain to the video path
  output logic [15:0] gain_out_r,
  // status
  output logic busy_r,
  output logic done_r,
  output logic err_r,
  output logic [1:0] err_code_r,
  output logic led_green_r
);
  doc_pkg::doc_state_e state_r, state_nxt; // sequencer
  logic [10:0] col_r, col_nxt; // walk column, 1-based
  logic [10:0] row_r, row_nxt; // walk row, 1-based
  logic cal_err_r, cal_err_nxt; // last run failed
  logic coef_wr_en_nxt;
  logic [10:0] coef_col_nxt;
  logic [10:0] coef_row_nxt;
  logic [7:0] coef_dat_nxt;
  logic nvm_save_nxt;
  logic [15:0] gain_out_nxt;
  logic busy_nxt;
  logic done_nxt;
  logic err_nxt;
  logic [1:0] err_code_nxt;
  logic args_ok; // pixel arguments in range
  logic last_pix; // walk on final pixel
  logic user_set; // user set selected

  // argument range check
  doc_arg_chk u_chk (
    .col(pix_col),
    .row(pix_row),
    .val(pix_val),
    .args_ok(args_ok)
  );

  // status lamp
  doc_led #(
    .HALF_CYC(LED_HALF_CYC)
  ) u_led (
    .core_clk(core_clk),
    .rstn(rstn),
    .busy(busy_r),
    .cal_err(cal_err_r),
    .led_green_r(led_green_r)
  );

  assign user_set = (coef_set_sel == doc_pkg::SET_USER);
  assign last_pix = (col_r == 11'(NUM_COLS)) && (row_r == 11'(NUM_ROWS));

  // sequencer and command decode
  always_comb begin
    state_nxt = state_r;
    col_nxt = col_r;
    row_nxt = row_r;
    cal_err_nxt = cal_err_r;
    coef_wr_en_nxt = 1'b0;
    coef_col_nxt = coef_col_r;
    coef_row_nxt = coef_row_r;
    coef_dat_nxt = coef_dat_r;
    nvm_save_nxt = 1'b0;
    done_nxt = 1'b0;
    err_nxt = 1'b0;
    err_code_nxt = err_code_r;
    case (state_r)
      doc_pkg::ST_IDLE: begin
        if (cal_start) begin
          // whole-sensor calibration, cal wins over pixel write
          if (!user_set) begin
            err_nxt = 1'b1;
            err_code_nxt = doc_pkg::ERR_SET;
            cal_err_nxt = 1'b1;
          end else if (!doc_pkg::mode_ok(exp_mode)) begin
            err_nxt = 1'b1;
            err_code_nxt = doc_pkg::ERR_MODE;
            cal_err_nxt = 1'b1;
          end else begin
            // start walking from pixel 1,1
            state_nxt = doc_pkg::ST_CAL;
            col_nxt = 11'h001;
            row_nxt = 11'h001;
            cal_err_nxt = 1'b0;
          end
        end else if (pix_wr) begin
          // single-pixel coefficient write
          if (!user_set) begin
            err_nxt = 1'b1;
            err_code_nxt = doc_pkg::ERR_SET;
          end else if (!args_ok) begin
            err_nxt = 1'b1;
            err_code_nxt = doc_pkg::ERR_ARG;
          end else begin
            coef_wr_en_nxt = 1'b1;
            coef_col_nxt = pix_col[10:0];
            coef_row_nxt = pix_row[10:0];
            coef_dat_nxt = pix_val[7:0];
            done_nxt = 1'b1;
          end
        end
      end
      doc_pkg::ST_CAL: begin
        if (cal_start || pix_wr) begin
          // commands are refused while computing
          err_nxt = 1'b1;
          err_code_nxt = doc_pkg::ERR_BUSY;
        end
        if (!user_set || !doc_pkg::mode_ok(exp_mode)) begin
          // preconditions lost mid-run: abort
          state_nxt = doc_pkg::ST_IDLE;
          err_nxt = 1'b1;
          err_code_nxt = user_set ? doc_pkg::ERR_MODE : doc_pkg::ERR_SET;
          cal_err_nxt = 1'b1;
        end else if (dark_valid) begin
          // dark level becomes the pixel's subtract coefficient
          coef_wr_en_nxt = 1'b1;
          coef_col_nxt = col_r;
          coef_row_nxt = row_r;
          coef_dat_nxt = doc_pkg::sat8(dark_data);
          if (last_pix) begin
            state_nxt = doc_pkg::ST_SAVE;
          end else if (col_r == 11'(NUM_COLS)) begin
            col_nxt = 11'h001;
            row_nxt = row_r + 11'h001;
          end else begin
            col_nxt = col_r + 11'h001;
          end
        end
      end
      doc_pkg::ST_SAVE: begin
        // commit coefficients without a save command
        nvm_save_nxt = 1'b1;
        done_nxt = 1'b1;
        state_nxt = doc_pkg::ST_IDLE;
      end
      default: begin
        state_nxt = doc_pkg::ST_IDLE;
      end
    endcase
    // unity gain for the whole run
    busy_nxt = (state_nxt != doc_pkg::ST_IDLE);
    gain_out_nxt = busy_nxt ? doc_pkg::GAIN_UNITY : user_gain;
  end

  // sequencer registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= doc_pkg::ST_IDLE;
      col_r <= 11'h001;
      row_r <= 11'h001;
      cal_err_r <= 1'b0;
      coef_wr_en_r <= 1'b0;
      coef_col_r <= 11'h000;
      coef_row_r <= 11'h000;
      coef_dat_r <= 8'h00;
      nvm_save_r <= 1'b0;
      gain_out_r <= 16'h0000;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      err_code_r <= 2'h0;
    end else begin
      state_r <= state_nxt;
      col_r <= col_nxt;
      row_r <= row_nxt;
      cal_err_r <= cal_err_nxt;
      coef_wr_en_r <= coef_wr_en_nxt;
      coef_col_r <= coef_col_nxt;
      coef_row_r <= coef_row_nxt;
      coef_dat_r <= coef_dat_nxt;
      nvm_save_r <= nvm_save_nxt;
      gain_out_r <= gain_out_nxt;
      busy_r <= busy_nxt;
      done_r <= done_nxt;
      err_r <= err_nxt;
      err_code_r <= err_code_nxt;
    end
  end

  // gain is unity whenever calibration runs
  a_gain_unity: assert property (
    @(posedge core_clk) disable iff (!rstn)
    busy_r |-> gain_out_r == doc_pkg::GAIN_UNITY)
    else $error("gain not unity during calibration");

  // factory set refuses calibration
  a_cal_set_rej: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && cal_start && !coef_set_sel)
    |=> err_r && err_code_r == doc_pkg::ERR_SET && !busy_r)
    else $error("calibration not refused with factory set");

  // bad mode refuses calibration, nothing starts
  a_cal_mode_rej: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && cal_start && coef_set_sel &&
     !doc_pkg::mode_ok(exp_mode))
    |=> err_r && !busy_r ##1 !coef_wr_en_r)
    else $error("calibration not refused in bad mode");

  // good mode and set start the run
  a_cal_starts: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && cal_start && coef_set_sel &&
     doc_pkg::mode_ok(exp_mode)) |=> busy_r && !err_r)
    else $error("calibration did not start");

  // dark sample written saturated at walk address
  a_cal_coef: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_CAL && user_set && doc_pkg::mode_ok(exp_mode)
     && dark_valid)
    |=> coef_wr_en_r && coef_dat_r == doc_pkg::sat8($past(dark_data))
        && coef_col_r == $past(col_r) && coef_row_r == $past(row_r))
    else $error("dark coefficient write wrong");

  // save follows the final pixel
  a_save_auto: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_CAL && user_set && doc_pkg::mode_ok(exp_mode)
     && dark_valid && last_pix) |=> ##1 nvm_save_r && done_r && !busy_r)
    else $error("no automatic save after calibration");

  // accepted pixel write reaches the store
  a_pix_write: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && !cal_start && pix_wr && coef_set_sel
     && args_ok)
    |=> coef_wr_en_r && coef_dat_r == $past(pix_val[7:0])
        && coef_col_r == $past(pix_col[10:0]) && done_r
        && coef_row_r == $past(pix_row[10:0]))
    else $error("pixel coefficient not written");

  // bad arguments leave store untouched
  a_pix_range: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && !cal_start && pix_wr && coef_set_sel
     && !args_ok) |=> !coef_wr_en_r && err_r && err_code_r == doc_pkg::ERR_ARG)
    else $error("out-of-range pixel write not rejected");

  // factory set refuses pixel write
  a_pix_set_rej: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && !cal_start && pix_wr && !coef_set_sel)
    |=> !coef_wr_en_r && err_r && err_code_r == doc_pkg::ERR_SET)
    else $error("pixel write not refused with factory set");

  // commands during a run are refused, run goes on
  a_busy_refuse: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_CAL && (cal_start || pix_wr) && user_set
     && doc_pkg::mode_ok(exp_mode))
    |=> err_r && err_code_r == doc_pkg::ERR_BUSY && busy_r)
    else $error("command during calibration not refused");

  // mode lost mid-run ends the run with no write
  a_abort_mode: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_CAL && user_set && !doc_pkg::mode_ok(exp_mode))
    |=> err_r && err_code_r == doc_pkg::ERR_MODE && !busy_r
        && !coef_wr_en_r)
    else $error("calibration not aborted on bad mode");

  // idle sequencer passes the user gain through
  a_gain_idle: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE && !cal_start)
    |=> !busy_r && gain_out_r == $past(user_gain))
    else $error("user gain not restored when idle");

  // save pulse only out of the save state
  a_save_once: assert property (
    @(posedge core_clk) disable iff (!rstn)
    nvm_save_r |-> done_r && !busy_r && $past(state_r) == doc_pkg::ST_SAVE)
    else $error("save pulse outside a finished run");

  // failed run leaves the lamp dark
  a_led_err: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (!busy_r && cal_err_r) |=> !led_green_r)
    else $error("lamp green after failed calibration");

  // idle store only written by an accepted pixel command
  a_idle_no_wr: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (state_r == doc_pkg::ST_IDLE
     && (cal_start || !pix_wr || !user_set || !args_ok))
    |=> !coef_wr_en_r)
    else $error("store written without accepted command");

  // walk writes stay inside the sensor
  a_walk_range: assert property (
    @(posedge core_clk) disable iff (!rstn)
    (coef_wr_en_r && busy_r)
    |-> coef_col_r >= 11'h001 && coef_col_r <= 11'(NUM_COLS)
        && coef_row_r >= 11'h001 && coef_row_r <= 11'(NUM_ROWS))
    else $error("walk address outside sensor");
endmodule
`default_nettype wire

/* design/doc_pkg.sv */
package doc_pkg;
  // coefficient set selector values
  localparam logic SET_FACTORY = 1'b0;
  localparam logic SET_USER = 1'b1;
  // exposure modes that allow calibration
  localparam logic [3:0] MODE_A = 4'h2;
  localparam logic [3:0] MODE_B = 4'h9;
  localparam logic [3:0] MODE_C = 4'ha;
  // unity digital gain setting
  localparam logic [15:0] GAIN_UNITY = 16'h1000;
  // argument limits of the pixel command
  localparam logic [15:0] COL_MIN = 16'h0001;
  localparam logic [15:0] COL_MAX = 16'h0578;
  localparam logic [15:0] ROW_MIN = 16'h0001;
  localparam logic [15:0] ROW_MAX = 16'h0400;
  localparam logic [15:0] VAL_MIN = 16'h0000;
  localparam logic [15:0] VAL_MAX = 16'h00ff;
  // sensor size walked by calibration
  localparam int NUM_COLS = 1400;
  localparam int NUM_ROWS = 1024;
  // error codes
  localparam logic [1:0] ERR_SET = 2'h1;
  localparam logic [1:0] ERR_MODE = 2'h2;
  localparam logic [1:0] ERR_ARG = 2'h3;
  localparam logic [1:0] ERR_BUSY = 2'h0;
  // led flash timing
  localparam int CLK_HZ = 20000000;
  localparam int LED_HALF_MS = 250;
  localparam int LED_HALF_CYC = LED_HALF_MS * (CLK_HZ / 1000);
  // command sequencer states
  typedef enum logic [1:0] {ST_IDLE, ST_CAL, ST_SAVE} doc_state_e;
  // exposure mode permits calibration
  function automatic logic mode_ok(input logic [3:0] m);
    mode_ok = (m == MODE_A) || (m == MODE_B) || (m == MODE_C);
  endfunction
  // clamp a dark level to the eight-bit coefficient
  function automatic logic [7:0] sat8(input logic [9:0] d);
    sat8 = (d > 10'h0ff) ? 8'hff : d[7:0];
  endfunction
endpackage

/* design/doc_arg_chk.sv */
`timescale 1ns/10ps
`default_nettype none
// range check of the pixel command arguments
module doc_arg_chk (
  // arguments
  input wire logic [15:0] col,
  input wire logic [15:0] row,
  input wire logic [15:0] val,
  // verdict
  output logic args_ok
);
  // inclusive range test
  function automatic logic in_rng(input logic [15:0] v,
                                  input logic [15:0] lo,
                                  input logic [15:0] hi);
    in_rng = (v >= lo) && (v <= hi);
  endfunction

  // all three arguments must pass
  assign args_ok = in_rng(col, doc_pkg::COL_MIN, doc_pkg::COL_MAX) &&
                   in_rng(row, doc_pkg::ROW_MIN, doc_pkg::ROW_MAX) &&
                   in_rng(val, doc_pkg::VAL_MIN, doc_pkg::VAL_MAX);
endmodule
`default_nettype wire

/* design/doc_led.sv */
`timescale 1ns/10ps
`default_nettype none
// status lamp: flashes green while busy, dark after a failed run, steady green otherwise
module doc_led #(
  parameter int HALF_CYC = doc_pkg::LED_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // status
  input wire logic busy,
  input wire logic cal_err,
  // lamp
  output logic led_green_r
);
  logic [22:0] cnt_r; // half-period counter
  logic [22:0] cnt_nxt;
  logic led_nxt;

  // next lamp state
  always_comb begin
    cnt_nxt = 23'h000000;
    led_nxt = 1'b1;
    if (busy) begin
      // flashing while coefficients are computed
      if (cnt_r >= 23'(HALF_CYC - 1)) begin
        led_nxt = ~led_green_r;
      end else begin
        cnt_nxt = cnt_r + 23'h000001;
        led_nxt = led_green_r;
      end
    end else if (cal_err) begin
      // no steady green after a failed run
      led_nxt = 1'b0;
    end
  end

  // lamp registers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_r <= 23'h000000;
      led_green_r <= 1'b1;
    end else begin
      cnt_r <= cnt_nxt;
      led_green_r <= led_nxt;
    end
  end

  a_led_steady: assert property (@(posedge core_clk) disable iff (!rstn)
    (!busy && !cal_err) |=> led_green_r)
    else $error("lamp not steady green when idle");
endmodule
`default_nettype wire

/* test/doc_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
// host side: dark frame source for a running calibration
module doc_host_model #(
  parameter int NPIX = 8
) (
  // clock
  input wire logic core_clk,
  // stream control from the bench
  input wire logic go,
  input wire logic slow,
  // dark pixel stream
  output var logic dark_valid,
  output var logic [9:0] dark_data
);
  int k; // pixels sent
  int w; // idle cycles left
  // lens capped, exposure correction off, analog offset zero
  initial begin
    k = 0;
    w = 0;
    dark_valid = 1'b0;
    dark_data = 10'h155;
  end
  // raster samples, prompt or gapped by three idle cycles
  always @(negedge core_clk) begin
    if (!go) begin
      k = 0;
      w = 0;
      dark_valid = 1'b0;
    end else if (w > 0) begin
      w = w - 1;
      dark_valid = 1'b0;
    end else if (k < NPIX) begin
      dark_valid = 1'b1;
      dark_data = 10'(k * 150);
      k = k + 1;
      w = slow ? 3 : 0;
    end else begin
      dark_valid = 1'b0;
    end
    // no stale level between samples
    if (!dark_valid) dark_data = ~dark_data;
  end
endmodule
`default_nettype wire

/* test/dark_offset_calibration_cmds_test.sv */
`timescale 1ns/10ps
`default_nettype none
// command level bench for the calibration block
module dark_offset_calibration_cmds_test;
  logic core_clk, rstn, coef_set_sel, cal_start, pix_wr, go, slow;
  logic [3:0] exp_mode;
  logic [15:0] user_gain, pix_col, pix_row, pix_val;
  logic dark_valid;
  logic [9:0] dark_data;
  logic coef_wr_en_r, nvm_save_r, busy_r, done_r, err_r, led_green_r;
  logic [10:0] coef_col_r, coef_row_r;
  logic [7:0] coef_dat_r;
  logic [15:0] gain_out_r;
  logic [1:0] err_code_r;
  int mismatches;
  int checks;
  // design with a 4 x 2 sensor and short flash
  doc_cal_top #(.NUM_COLS(4), .NUM_ROWS(2), .LED_HALF_CYC(4))
  u_doc_cal_top (.core_clk(core_clk), .rstn(rstn),
    .coef_set_sel(coef_set_sel), .exp_mode(exp_mode),
    .user_gain(user_gain), .cal_start(cal_start), .pix_wr(pix_wr),
    .pix_col(pix_col), .pix_row(pix_row), .pix_val(pix_val),
    .dark_valid(dark_valid), .dark_data(dark_data),
    .coef_wr_en_r(coef_wr_en_r), .coef_col_r(coef_col_r),
    .coef_row_r(coef_row_r), .coef_dat_r(coef_dat_r),
    .nvm_save_r(nvm_save_r), .gain_out_r(gain_out_r),
    .busy_r(busy_r), .done_r(done_r), .err_r(err_r),
    .err_code_r(err_code_r), .led_green_r(led_green_r));
  // host model feeding dark samples
  doc_host_model #(.NPIX(8)) u_doc_host_model (.core_clk(core_clk),
    .go(go), .slow(slow), .dark_valid(dark_valid),
    .dark_data(dark_data));
  // 50 ns clock
  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end
  // compare and count
  task automatic chk(input logic [15:0] got, input logic [15:0] exp,
                     input string what);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
  endtask
  // single-pixel command, answer one cycle later
  task automatic pix(input logic [15:0] c, input logic [15:0] r,
                     input logic [15:0] v, input logic [1:0] ec,
                     input logic ok);
    pix_col = c;
    pix_row = r;
    pix_val = v;
    pix_wr = 1'b1;
    @(negedge core_clk);
    pix_wr = 1'b0;
    chk(coef_wr_en_r, ok, "pixel write");
    chk(done_r, ok, "pixel done");
    chk(err_r, !ok, "pixel error");
    if (ok) begin
      chk(coef_col_r, c, "column");
      chk(coef_row_r, r, "row");
      chk(coef_dat_r, v, "value");
    end else begin
      chk(err_code_r, ec, "pixel code");
    end
    @(negedge core_clk);
  endtask
  // whole-sensor command; fast runs also probe the busy refusal
  task automatic cal(input logic [1:0] ec, input logic ok,
                     input logic sl);
    int n, t, tog, e;
    logic lp;
    n = 0;
    tog = 0;
    slow = sl;
    cal_start = 1'b1;
    @(negedge core_clk);
    cal_start = 1'b0;
    if (!ok) begin
      chk(err_r, 1'b1, "cal refused");
      chk(err_code_r, ec, "cal code");
      chk(busy_r, 1'b0, "cal idle");
    end else begin
      go = 1'b1;
      lp = led_green_r;
      for (t = 0; t < 200 && busy_r === 1'b1; t++) begin
        chk(gain_out_r, doc_pkg::GAIN_UNITY, "unity gain");
        if (coef_wr_en_r === 1'b1) begin
          e = (n * 150) % 1024;
          chk(coef_col_r, 16'(n % 4 + 1), "cal column");
          chk(coef_row_r, 16'(n / 4 + 1), "cal row");
          chk(coef_dat_r, 16'(e > 255 ? 255 : e), "cal coef");
          n++;
        end
        if (led_green_r !== lp) tog++;
        lp = led_green_r;
        if (!sl && t == 2) pix_wr = 1'b1;
        if (!sl && t == 3) begin
          pix_wr = 1'b0;
          chk(err_r, 1'b1, "busy refusal");
          chk(err_code_r, doc_pkg::ERR_BUSY, "busy code");
        end
        @(negedge core_clk);
      end
      go = 1'b0;
      chk(16'(n), 16'h0008, "write count");
      chk(nvm_save_r, 1'b1, "save pulse");
      chk(done_r, 1'b1, "cal done");
      chk(gain_out_r, user_gain, "gain back");
      if (sl) chk(16'(tog > 1), 16'h0001, "lamp flash");
    end
    @(negedge core_clk);
    if (ok) chk(led_green_r, 1'b1, "lamp steady");
  endtask
  // verdict
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // hang guard
  initial begin
    #(50 * 4000);
    mismatches++;
    end_of_test();
  end
  // pixel command argument table: col, row, val, accepted
  logic [15:0] tc[7] = '{16'h0001, 16'h0578, 16'h0000, 16'h0579,
                         16'h0001, 16'h0001, 16'h0005};
  logic [15:0] tr[7] = '{16'h0001, 16'h0400, 16'h0001, 16'h0001,
                         16'h0000, 16'h0401, 16'h0005};
  logic [15:0] tv[7] = '{16'h0000, 16'h00ff, 16'h0007, 16'h0007,
                         16'h0007, 16'h0007, 16'h0100};
  logic tok[7] = '{1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
  // main sequence
  initial begin
    mismatches = 0;
    checks = 0;
    rstn = 1'b0;
    coef_set_sel = doc_pkg::SET_USER;
    exp_mode = 4'h2;
    user_gain = 16'h0800;
    {cal_start, pix_wr, go, slow} = 4'h0;
    pix_col = 16'h0001;
    pix_row = 16'h0001;
    pix_val = 16'h0000;
    repeat (8) @(posedge core_clk);
    @(negedge core_clk);
    chk(led_green_r, 1'b1, "reset lamp");
    chk(busy_r, 1'b0, "reset busy");
    rstn = 1'b1;
    @(negedge core_clk);
    chk(gain_out_r, user_gain, "idle gain");
    $display("test reset done");
    for (int i = 0; i < 7; i++) begin
      pix(tc[i], tr[i], tv[i],
          doc_pkg::ERR_ARG, tok[i]);
    end
    $display("test pixel done");
    coef_set_sel = doc_pkg::SET_FACTORY;
    pix(16'h0002, 16'h0002, 16'h0003, doc_pkg::ERR_SET, 1'b0);
    cal(doc_pkg::ERR_SET, 1'b0, 1'b0);
    coef_set_sel = doc_pkg::SET_USER;
    $display("test factory done");
    for (int m = 0; m < 16; m++) begin
      exp_mode = 4'(m);
      cal(doc_pkg::ERR_MODE, m == 2 || m == 9 || m == 10,
          m == 9);
    end
    $display("test modes done");
    exp_mode = 4'h9;
    cal_start = 1'b1;
    @(negedge core_clk);
    cal_start = 1'b0;
    go = 1'b1;
    repeat (3) @(negedge core_clk);
    exp_mode = 4'h0;
    @(negedge core_clk);
    chk(err_r, 1'b1, "abort error");
    chk(busy_r, 1'b0, "abort idle");
    go = 1'b0;
    exp_mode = 4'ha;
    @(negedge core_clk);
    chk(led_green_r, 1'b0, "abort lamp");
    cal(2'h0, 1'b1, 1'b0);
    $display("test abort done");
    end_of_test();
  end
endmodule
`default_nettype wire
